/* File: core/sst_timer_top.sv */
// State event timer: counter, events, state variable and actions
`timescale 1ns/1ps
module sst_timer_top #(
  parameter int CNT_W = 16,
  parameter int N_EV = 8,
  parameter int N_ST = 8,
  parameter int ST_W = 3,
  parameter int N_MATCH = 4,
  parameter int MS_W = 2,
  parameter int N_IN = 4,
  parameter int N_OUT = 4,
  parameter int N_DMA = 2
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Input sources
  input wire logic [3:0] sw_pin,
  input wire logic adc_thr_irq,
  input wire logic cmp_out,
  input wire logic core_event_out,
  input wire logic core_debug_halt,
  input wire logic [N_IN-1:0][sst_pkg::SRC_W-1:0] timer_input_source_select,
  // Counter control
  input wire logic bidir,
  input wire logic auto_limit,
  input wire logic sw_start,
  input wire logic sw_stop,
  input wire logic sw_unhalt,
  input wire logic [N_MATCH-1:0][CNT_W-1:0] match_val,
  input wire logic [MS_W-1:0] adc_trig_sel,
  // Event configuration
  input wire logic [N_EV-1:0][N_ST-1:0] ev_state_mask,
  input wire logic [N_EV-1:0][MS_W-1:0] ev_match_sel,
  input wire logic [N_EV-1:0][sst_pkg::IO_W-1:0] ev_io_sel,
  input wire logic [N_EV-1:0][1:0] ev_io_cond,
  input wire logic [N_EV-1:0][1:0] ev_comb,
  input wire logic [N_EV-1:0][1:0] ev_dir,
  input wire logic [N_EV-1:0] ev_match_hold,
  input wire logic [N_EV-1:0] ev_load_state,
  input wire logic [N_EV-1:0][ST_W-1:0] ev_next_state,
  input wire logic [N_EV-1:0][N_OUT-1:0] ev_out_toggle,
  // Event actions
  input wire logic [N_EV-1:0] ev_limit,
  input wire logic [N_EV-1:0] ev_halt,
  input wire logic [N_EV-1:0] ev_start,
  input wire logic [N_EV-1:0] ev_stop,
  input wire logic [N_EV-1:0] ev_reverse,
  input wire logic [N_DMA-1:0][N_EV-1:0] dma_ev_mask,
  input wire logic [N_EV-1:0] ev_irq_en,
  input wire logic [N_EV-1:0] ev_flag_clr,
  // Status and outputs
  output logic [CNT_W-1:0] count,
  output logic [ST_W-1:0] state,
  output logic running,
  output logic halted,
  output logic dir_up,
  output logic [N_OUT-1:0] out_q,
  output logic [N_EV-1:0] ev_flag,
  output logic irq,
  output logic [N_DMA-1:0] dma_req,
  output logic adc_trig
);
  sst_in_if #(.N_IN(N_IN)) ins ();

  sst_timer_input_source_select #(.N_IN(N_IN)) u_mux (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .sw_pin(sw_pin),
    .adc_thr_irq(adc_thr_irq),
    .cmp_out(cmp_out),
    .core_event_out(core_event_out),
    .core_debug_halt(core_debug_halt),
    .timer_input_source_select(timer_input_source_select),
    .ins(ins.prod)
  );

  logic [N_OUT-1:0] out_prev;
  logic [N_EV-1:0] match_lat;
  logic [N_MATCH-1:0] match_now;
  logic [N_EV-1:0] fire;
  logic [N_EV-1:0] m_term;
  logic lim;
  logic next_run, next_halt, next_dir, next_irq, next_adc;
  logic [CNT_W-1:0] next_count;
  logic [ST_W-1:0] next_state;
  logic [N_OUT-1:0] next_out;
  logic [N_EV-1:0] next_flag, next_lat;
  logic [N_DMA-1:0] next_dma;

  always_comb begin
    logic lv, rs, fl, io, dok, d;
    logic [1:0] ix;
    lv = 1'b0;
    rs = 1'b0;
    fl = 1'b0;
    io = 1'b0;
    dok = 1'b0;
    d = 1'b0;
    ix = '0;
    for (int m = 0; m < N_MATCH; m++) begin
      match_now[m] = (count == match_val[m]);
    end
    next_out = out_q;
    next_state = state;
    for (int e = N_EV - 1; e >= 0; e--) begin
      ix = ev_io_sel[e][1:0];
      if (ev_io_sel[e][sst_pkg::IO_OUT_BIT]) begin
        lv = out_q[ix];
        rs = out_q[ix] & ~out_prev[ix];
        fl = ~out_q[ix] & out_prev[ix];
      end else begin
        lv = ins.level[ix];
        rs = ins.rise[ix];
        fl = ins.fall[ix];
      end
      unique case (ev_io_cond[e])
        sst_pkg::COND_LOW: io = ~lv;
        sst_pkg::COND_RISE: io = rs;
        sst_pkg::COND_FALL: io = fl;
        sst_pkg::COND_HIGH: io = lv;
      endcase
      // Held matches count until the event fires
      m_term[e] = match_now[ev_match_sel[e]] | match_lat[e];
      unique case (ev_comb[e])
        sst_pkg::COMB_OR: io = m_term[e] | io;
        sst_pkg::COMB_MATCH: io = m_term[e];
        sst_pkg::COMB_IO: io = io;
        sst_pkg::COMB_AND: io = m_term[e] & io;
      endcase
      // Direction qualifier only matters when counting both ways
      dok = !bidir || ev_dir[e] == sst_pkg::DIR_BOTH ||
            (ev_dir[e] == sst_pkg::DIR_UP && dir_up) ||
            (ev_dir[e] == sst_pkg::DIR_DOWN && !dir_up);
      fire[e] = ev_state_mask[e][state] & io & dok;
      next_out = next_out ^ (fire[e] ? ev_out_toggle[e] : '0);
      // Lowest numbered firing event wins the state load
      if (fire[e] && ev_load_state[e]) begin
        next_state = ev_next_state[e];
      end
    end
    next_lat = (match_lat | (m_term & ev_match_hold)) & ~fire;
    lim = |(fire & ev_limit) | (auto_limit & match_now[0]);
    // Stop wins over start when both arrive together
    next_run = running;
    if (sw_start || |(fire & ev_start)) begin
      next_run = 1'b1;
    end
    if (sw_stop || |(fire & ev_stop)) begin
      next_run = 1'b0;
    end
    next_halt = (halted & ~sw_unhalt) | |(fire & ev_halt);
    d = dir_up ^ |(fire & ev_reverse);
    next_count = count;
    next_dir = d;
    // Limit and wrap never touch the state variable
    if (running && !halted) begin
      if (!bidir) begin
        next_dir = 1'b1;
        next_count = lim ? '0 : count + 1'b1;
      end else if (d) begin
        next_dir = ~lim;
        next_count = lim ? count - 1'b1 : count + 1'b1;
      end else begin
        next_dir = (count == '0);
        next_count = (count == '0) ? count + 1'b1 : count - 1'b1;
      end
    end
    // A new event beats a clear in the same cycle
    next_flag = (ev_flag & ~ev_flag_clr) | fire;
    next_irq = |(next_flag & ev_irq_en);
    for (int k = 0; k < N_DMA; k++) begin
      next_dma[k] = |(fire & dma_ev_mask[k]);
    end
    next_adc = match_now[adc_trig_sel];
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      count <= '0;
      state <= sst_pkg::STATE_RST;
      running <= 1'b0;
      halted <= 1'b0;
      dir_up <= 1'b1;
      out_q <= {N_OUT{sst_pkg::OUT_RST}};
      out_prev <= {N_OUT{sst_pkg::OUT_RST}};
      ev_flag <= '0;
      match_lat <= '0;
      irq <= 1'b0;
      dma_req <= '0;
      adc_trig <= 1'b0;
    end else begin
      count <= next_count;
      state <= next_state;
      running <= next_run;
      halted <= next_halt;
      dir_up <= next_dir;
      out_q <= next_out;
      out_prev <= out_q;
      ev_flag <= next_flag;
      match_lat <= next_lat;
      irq <= next_irq;
      dma_req <= next_dma;
      adc_trig <= next_adc;
    end
  end

  // Events that the direction qualifier must refuse in this cycle
  logic [N_EV-1:0] dir_wrong;
  always_comb begin
    for (int e = 0; e < N_EV; e++) begin
      dir_wrong[e] = bidir && ((ev_dir[e] == sst_pkg::DIR_UP && !dir_up) ||
                     (ev_dir[e] == sst_pkg::DIR_DOWN && dir_up));
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  chk_flag_set: assert property (|fire |=>
    (ev_flag & $past(fire)) == $past(fire))
    else $error("event flag not latched");
  chk_irq_gate: assert property (##1 irq ==
    |(ev_flag & $past(ev_irq_en))) else $error("irq disagrees with flags");
  chk_state_load: assert property (fire[0] && ev_load_state[0] |=>
    state == $past(ev_next_state[0])) else $error("state not loaded");
  chk_state_hold: assert property (fire == '0 |=>
    $stable(state)) else $error("state moved without event");
  chk_auto_limit: assert property (running && !halted && !bidir &&
    auto_limit && count == match_val[0] |=> count == '0)
    else $error("auto limit missed");
  chk_stop_event: assert property (|(fire & ev_stop) |=> !running)
    else $error("stop event ignored");
  chk_halt_freeze: assert property (halted && !sw_unhalt |=>
    halted && $stable(count)) else $error("halt not held");
  chk_out_quiet: assert property (fire == '0 |=> $stable(out_q))
    else $error("output toggled without event");
  chk_dir_filter: assert property ((fire & dir_wrong) == '0)
    else $error("direction filter broken");
  chk_adc_trig: assert property (count ==
    match_val[adc_trig_sel] |=> adc_trig)
    else $error("converter trigger missed");

  cov_state_load: cover property (fire[0] && ev_load_state[0]);
  cov_halt: cover property ($rose(halted));
  cov_reverse: cover property (bidir && dir_up ##1 !dir_up);
  cov_irq: cover property ($rose(irq));
endmodule

/* File: core/sst_pkg.sv */
// Shared constants and encodings for the state event timer
package sst_pkg;
  // Input source multiplexer
  localparam int N_SRC = 8;
  localparam int SRC_W = 3;
  localparam logic [2:0] SRC_PIN0 = 3'h0;
  localparam logic [2:0] SRC_ADC_THR = 3'h4;
  localparam logic [2:0] SRC_CMP = 3'h5;
  localparam logic [2:0] SRC_CORE_EV = 3'h6;
  localparam logic [2:0] SRC_DBG_HALT = 3'h7;
  // Input/output condition select: bit 2 picks an output, bits 1:0 its index
  localparam int IO_W = 3;
  localparam int IO_OUT_BIT = 2;
  // Input/output condition
  localparam logic [1:0] COND_LOW = 2'h0;
  localparam logic [1:0] COND_RISE = 2'h1;
  localparam logic [1:0] COND_FALL = 2'h2;
  localparam logic [1:0] COND_HIGH = 2'h3;
  // How match and input/output terms combine
  localparam logic [1:0] COMB_OR = 2'h0;
  localparam logic [1:0] COMB_MATCH = 2'h1;
  localparam logic [1:0] COMB_IO = 2'h2;
  localparam logic [1:0] COMB_AND = 2'h3;
  // Count direction qualifier
  localparam logic [1:0] DIR_BOTH = 2'h0;
  localparam logic [1:0] DIR_UP = 2'h1;
  localparam logic [1:0] DIR_DOWN = 2'h2;
  // Reset values
  localparam logic [2:0] STATE_RST = 3'h0;
  localparam logic OUT_RST = 1'h0;
endpackage

/* File: core/sst_in_if.sv */
// Conditioned timer inputs passed from the source mux to the event logic
`timescale 1ns/1ps
interface sst_in_if #(parameter int N_IN = 4);
  logic [N_IN-1:0] level;
  logic [N_IN-1:0] rise;
  logic [N_IN-1:0] fall;
  modport prod (output level, output rise, output fall);
  modport cons (input level, input rise, input fall);
endinterface

/* File: core/sst_timer_input_source_select.sv */
// Per-input source selection, synchronisation and edge detection
`timescale 1ns/1ps
module sst_timer_input_source_select #(
  parameter int N_IN = 4
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Raw sources
  input wire logic [3:0] sw_pin,
  input wire logic adc_thr_irq,
  input wire logic cmp_out,
  input wire logic core_event_out,
  input wire logic core_debug_halt,
  // Source select per input
  input wire logic [N_IN-1:0][sst_pkg::SRC_W-1:0] timer_input_source_select,
  // Conditioned inputs
  sst_in_if.prod ins
);
  logic [sst_pkg::N_SRC-1:0] raw;
  logic [sst_pkg::N_SRC-1:0] sync1;
  logic [sst_pkg::N_SRC-1:0] sync2;
  logic [N_IN-1:0] lvl;
  logic [N_IN-1:0] prev;
  logic [N_IN-1:0] next_lvl;

  // Same eight sources offered to every input
  assign raw = {core_debug_halt, core_event_out, cmp_out, adc_thr_irq,
                sw_pin};

  // All sources are asynchronous to ref_clk, so sync before the mux
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1 <= '0;
      sync2 <= '0;
      lvl <= '0;
      prev <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      lvl <= next_lvl;
      prev <= lvl;
    end
  end

  genvar i;
  generate
    for (i = 0; i < N_IN; i++) begin : g_in
      // Exactly one source routed to each input
      assign next_lvl[i] = sync2[timer_input_source_select[i]];
      assign ins.level[i] = lvl[i];
      assign ins.rise[i] = lvl[i] & ~prev[i];
      assign ins.fall[i] = ~lvl[i] & prev[i];
    end
  endgenerate
endmodule

/* File: tb/sst_src_model.sv */
// Model of the pins, comparator, converter and core signals feeding the mux
`timescale 1ns/1ps
module sst_src_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Requested levels: 3:0 pins, 4 converter, 5 comparator, 6/7 core
  input wire logic [7:0] drv,
  // Source lines
  output logic [3:0] sw_pin,
  output logic adc_thr_irq,
  output logic cmp_out,
  output logic core_event_out,
  output logic core_debug_halt
);
  // Launched from flops on the timer's own ref_clk, so always in step with the timer
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      {core_debug_halt, core_event_out, cmp_out, adc_thr_irq, sw_pin} <= 8'h00;
    end else begin
      {core_debug_halt, core_event_out, cmp_out, adc_thr_irq, sw_pin} <= drv;
    end
  end
endmodule

/* File: tb/state_event_timer_test.sv */
// Bench for the state event timer: reset, counting, events and source mux
`timescale 1ns/1ps
module state_event_timer_test;
  logic ref_clk, reset_n, bidir, auto_limit, sw_start, sw_stop, sw_unhalt;
  logic adc_thr_irq, cmp_out, core_event_out, core_debug_halt;
  logic running, halted, dir_up, irq, adc_trig;
  logic [3:0] sw_pin, out_q;
  logic [7:0] src_drv, ev_match_hold, ev_load_state, ev_limit, ev_halt;
  logic [7:0] ev_start, ev_stop, ev_reverse, ev_irq_en, ev_flag_clr, ev_flag;
  logic [3:0][2:0] timer_input_source_select;
  logic [3:0][15:0] match_val;
  logic [1:0] adc_trig_sel, dma_req;
  logic [7:0][7:0] ev_state_mask;
  logic [7:0][1:0] ev_match_sel, ev_io_cond, ev_comb, ev_dir;
  logic [7:0][2:0] ev_io_sel, ev_next_state;
  logic [7:0][3:0] ev_out_toggle;
  logic [1:0][7:0] dma_ev_mask;
  logic [15:0] count, held;
  logic [2:0] state;
  int fails = 0;
  int num_checks = 0;

  sst_src_model i_src (.ref_clk, .reset_n, .drv(src_drv), .sw_pin,
    .adc_thr_irq, .cmp_out, .core_event_out, .core_debug_halt);

  sst_timer_top i_dut (.ref_clk, .reset_n, .sw_pin, .adc_thr_irq, .cmp_out,
    .core_event_out, .core_debug_halt, .timer_input_source_select, .bidir,
    .auto_limit, .sw_start, .sw_stop, .sw_unhalt, .match_val, .adc_trig_sel,
    .ev_state_mask, .ev_match_sel, .ev_io_sel, .ev_io_cond, .ev_comb, .ev_dir,
    .ev_match_hold, .ev_load_state, .ev_next_state, .ev_out_toggle, .ev_limit,
    .ev_halt, .ev_start, .ev_stop, .ev_reverse, .dma_ev_mask, .ev_irq_en,
    .ev_flag_clr, .count, .state, .running, .halted, .dir_up, .out_q,
    .ev_flag, .irq, .dma_req, .adc_trig);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Waits on a settled output: 0 count, 1 state, 2 direction
  task automatic wait_for(input int which, input logic [15:0] v);
    logic [15:0] cur;
    for (int i = 0; i < 200; i++) begin
      @(negedge ref_clk);
      cur = (which == 0) ? count : (which == 1) ? 16'(state) : 16'(dir_up);
      if (cur === v) return;
    end
    fails++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask

  task automatic clear_flags();
    @(posedge ref_clk) ev_flag_clr <= 8'hff;
    @(posedge ref_clk) ev_flag_clr <= 8'h00;
  endtask

  initial begin
    reset_n = 1'b0;
    {bidir, sw_start, sw_stop, sw_unhalt} = 4'h0;
    auto_limit = 1'b1;
    src_drv = 8'h00;
    {ev_match_hold, ev_limit, ev_start, ev_stop, ev_reverse} = '0;
    {ev_flag_clr, ev_io_sel, ev_io_cond, ev_comb, ev_dir} = '0;
    {ev_state_mask, ev_match_sel, ev_load_state, ev_next_state} = '0;
    {ev_out_toggle, ev_halt, ev_irq_en, dma_ev_mask} = '0;
    timer_input_source_select = '0;
    timer_input_source_select[0] = sst_pkg::SRC_CMP;
    match_val = {16'h0000, 16'h0000, 16'h0002, 16'h0005};
    adc_trig_sel = 2'h1;
    // Event 0: match 1 in state 0 goes to state 1, toggles, flags, DMA
    ev_state_mask[0] = 8'h01;
    ev_match_sel[0] = 2'h1;
    ev_comb[0] = sst_pkg::COMB_MATCH;
    ev_next_state[0] = 3'h1;
    ev_out_toggle[0] = 4'h1;
    ev_irq_en[0] = 1'b1;
    dma_ev_mask[0] = 8'h01;
    // Event 1: input 0 rising in state 1 goes to state 2 and halts
    ev_state_mask[1] = 8'h02;
    ev_next_state[1] = 3'h2;
    ev_halt[1] = 1'b1;
    // Event 2: input 0 rising in state 2, flag only
    ev_state_mask[2] = 8'h04;
    ev_load_state = 8'h03;
    ev_io_cond = {8{sst_pkg::COND_RISE}};
    ev_comb[2:1] = {sst_pkg::COMB_IO, sst_pkg::COMB_IO};
    repeat (6) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    check({count, 16'(state)}, 32'h0);
    check({running, dir_up, out_q, ev_flag, irq}, 16'h2000);
    @(posedge ref_clk) sw_start <= 1'b1;
    @(posedge ref_clk) sw_start <= 1'b0;
    wait_for(1, 16'h1);
    check(count, 16'h0003);
    check({ev_flag, irq, out_q}, 16'h0031);
    check({dma_req, adc_trig}, 16'h3);
    @(negedge ref_clk);
    check(dma_req, 16'h0);
    wait_for(0, 16'h5);
    @(negedge ref_clk);
    check({count, 16'(state)}, 32'h1);
    wait_for(0, 16'h3);
    check(out_q, 16'h1);
    clear_flags();
    @(negedge ref_clk);
    check({ev_flag, irq}, 16'h0);
    @(posedge ref_clk) src_drv <= 8'h20;
    wait_for(1, 16'h2);
    check({halted, ev_flag}, 16'h102);
    held = count;
    repeat (3) @(negedge ref_clk);
    check(count, held);
    for (int s = 0; s < 8; s++) begin
      @(posedge ref_clk);
      timer_input_source_select[0] <= 3'(s);
      src_drv <= 8'h00;
      repeat (6) @(posedge ref_clk);
      clear_flags();
      src_drv <= 8'h01 << s;
      repeat (8) @(negedge ref_clk);
      check(ev_flag, 16'h4);
    end
    @(posedge ref_clk) {bidir, sw_unhalt} <= 2'h3;
    @(posedge ref_clk) sw_unhalt <= 1'b0;
    wait_for(2, 16'h0);
    check({count, 16'(state)}, 32'h40002);
    // Event 3: match 2 and output 0 high together stop the count
    @(posedge ref_clk);
    ev_state_mask[3] <= 8'h04;
    ev_match_sel[3] <= 2'h2;
    ev_io_sel[3] <= 3'h4;
    ev_io_cond[3] <= sst_pkg::COND_HIGH;
    ev_comb[3] <= sst_pkg::COMB_AND;
    ev_stop <= 8'h08;
    ev_load_state <= 8'h0b;
    ev_next_state[3] <= 3'h3;
    wait_for(1, 16'h3);
    repeat (2) @(negedge ref_clk);
    check({running, dir_up, count}, 32'h10001);
    check(ev_flag, 16'h000c);
    // Level start with reverse, then direction-qualified and held matches
    @(posedge ref_clk);
    ev_state_mask <= {8'h20, 8'h10, 8'h10, 8'h08, ev_state_mask[3:0]};
    ev_io_cond <= {sst_pkg::COND_FALL, sst_pkg::COND_LOW, ev_io_cond[5],
      sst_pkg::COND_HIGH, ev_io_cond[3:0]};
    ev_comb <= {sst_pkg::COMB_AND, sst_pkg::COMB_OR, sst_pkg::COMB_MATCH,
      sst_pkg::COMB_IO, ev_comb[3:0]};
    ev_match_sel <= {2'h3, 2'h2, 2'h2, ev_match_sel[4:0]};
    ev_dir <= {sst_pkg::DIR_BOTH, sst_pkg::DIR_DOWN, sst_pkg::DIR_UP,
      ev_dir[4:0]};
    ev_next_state <= {3'h6, 3'h5, 3'h0, 3'h4, ev_next_state[3:0]};
    ev_load_state <= 8'hdb;
    {ev_start, ev_reverse, ev_match_hold} <= {8'h10, 8'h10, 8'h80};
    dma_ev_mask[1] <= 8'h10;
    wait_for(1, 16'h4);
    check({dma_req, running, dir_up, count}, 32'ha0001);
    wait_for(1, 16'h5);
    check(ev_flag, 16'h005c);
    // Input falls while count is far from match 3: only the held match fires
    @(posedge ref_clk) src_drv <= 8'h00;
    wait_for(1, 16'h6);
    check({ev_flag, irq}, 16'h01b8);
    close_out();
  end
endmodule
